// ---- src/tmc_mute_control.sv ----
// transmitter mute control: fault latch, reset one-shot, keying mute
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_mute_control
  import tmc_pkg::*;
#(
  parameter int RESET_PULSE_CYC = `TMC_RESET_PULSE_CYC,
  parameter int DEBOUNCE_CYC = `TMC_DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // amplifier status and front-panel pins
  input wire tmc_pins_s pins,
  // keying source selector and voice-mode flag
  input wire tmc_key_e keySelect,
  input wire logic voiceMode,
  // indicators and mute command
  output tmc_out_s outs
);
  localparam int PW = $clog2(RESET_PULSE_CYC + 1);
  if (RESET_PULSE_CYC < 2) begin : gBadPulse
    $error("reset pulse count too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // input conditioning
  logic ampFaultNF, reducedPowerF, presselF, speechF, resetReqF;
  logic lockS1_r, lockS2_r, lockS3_r;

  tmc_input_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b1)) uFault (
    .ref_clk(ref_clk), .rst(rst), .pinIn(pins.ampFaultN), .levelOut(ampFaultNF));
  tmc_input_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b0)) uRedPwr (
    .ref_clk(ref_clk), .rst(rst), .pinIn(pins.reducedPower), .levelOut(reducedPowerF));
  tmc_input_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b0)) uPressel (
    .ref_clk(ref_clk), .rst(rst), .pinIn(pins.pressel), .levelOut(presselF));
  tmc_input_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b0)) uSpeech (
    .ref_clk(ref_clk), .rst(rst), .pinIn(pins.speechDetect), .levelOut(speechF));
  tmc_input_filter #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .RESET_VAL(1'b0)) uReset (
    .ref_clk(ref_clk), .rst(rst), .pinIn(pins.resetReq), .levelOut(resetReqF));

  // lock loss is a short pulse, so no debounce: it would be filtered away
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lockS1_r <= 1'b1;
      lockS2_r <= 1'b1;
      lockS3_r <= 1'b1;
    end else begin
      lockS1_r <= pins.lockLossN;
      lockS2_r <= lockS1_r;
      lockS3_r <= lockS2_r;
    end
  end
  wire lockLoss = !lockS2_r && !lockS3_r;
  wire ampFault = !ampFaultNF;

  ////////////////////////////////////////////////////////////////////////
  // reset one-shot
  logic resetReqD_r;
  logic [PW-1:0] pulseCnt_r;
  wire resetRise = resetReqF && !resetReqD_r;
  wire pulseActive = (pulseCnt_r != '0);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      resetReqD_r <= 1'b0;
      pulseCnt_r <= '0;
    end else begin
      resetReqD_r <= resetReqF;
      if (resetRise && !pulseActive) begin
        pulseCnt_r <= PW'(RESET_PULSE_CYC);
      end else if (pulseActive) begin
        pulseCnt_r <= pulseCnt_r - PW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault latch
  logic faultLatch_r;
  wire faultSet = ampFault || lockLoss;
  // clear is held by the pulse; a standing fault re-sets, so set wins
  logic faultLatch_nxt;
  assign faultLatch_nxt = faultSet ? 1'b1 : (pulseActive ? 1'b0 : faultLatch_r);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      faultLatch_r <= `TMC_LATCH_RESET_VAL;
    end else begin
      faultLatch_r <= faultLatch_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mute combine gate
  // pressel released mutes
  wire presselMute = (keySelect == TMC_KEY_PTT) && !presselF;
  wire voxMute = (keySelect == TMC_KEY_VOX) && voiceMode && !speechF;
  logic muteCmd_r, resetLamp_r, redPwrLamp_r, resetPulse_r;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      muteCmd_r <= 1'b1;
      resetLamp_r <= 1'b1;
      redPwrLamp_r <= 1'b0;
      resetPulse_r <= 1'b0;
    end else begin
      muteCmd_r <= faultLatch_nxt || presselMute || voxMute;
      resetLamp_r <= faultLatch_nxt;
      redPwrLamp_r <= reducedPowerF;
      resetPulse_r <= pulseActive;
    end
  end

  // one packed word keeps the output struct to a single driver
  assign outs = {muteCmd_r, resetLamp_r, redPwrLamp_r, resetPulse_r};

  ////////////////////////////////////////////////////////////////////////
  // checks: latch and lamp
  // latch lights lamp
  chk_latch_lamp_mute: assert property (@(posedge ref_clk) disable iff (rst)
    faultLatch_r |-> (outs.resetLamp && outs.muteCmd))
    else $error("latch set but lamp or mute missing");
  chk_fault_sets: assert property (@(posedge ref_clk) disable iff (rst)
    ampFault |=> (faultLatch_r && outs.resetLamp))
    else $error("fault did not set latch");
  chk_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    (faultSet && pulseActive) |=> faultLatch_r)
    else $error("standing fault lost to reset pulse");
  chk_latch_holds_set: assert property (@(posedge ref_clk) disable iff (rst)
    (faultLatch_r && !pulseActive) |=> faultLatch_r)
    else $error("latch dropped without reset pulse");
  chk_clear_needs_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(faultLatch_r) |-> $past(pulseActive))
    else $error("latch cleared without reset pulse");
  chk_lock_sets: assert property (@(posedge ref_clk) disable iff (rst)
    lockLoss |=> (faultLatch_r && outs.muteCmd))
    else $error("lock loss did not set latch");

  ////////////////////////////////////////////////////////////////////////
  // checks: indicators and keying
  // lamp follows input
  chk_redpwr_follow: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (outs.reducedPowerLamp == $past(reducedPowerF)))
    else $error("reduced power lamp mismatch");
  chk_redpwr_off: assert property (@(posedge ref_clk) disable iff (rst)
    !reducedPowerF |=> !outs.reducedPowerLamp)
    else $error("reduced power lamp stayed lit");
  chk_ptt_mute: assert property (@(posedge ref_clk) disable iff (rst)
    (keySelect == TMC_KEY_PTT && !presselF) |=> outs.muteCmd)
    else $error("pressel released but not muted");
  chk_ptt_unmute: assert property (@(posedge ref_clk) disable iff (rst)
    (keySelect == TMC_KEY_PTT && presselF && !faultLatch_nxt) |=> !outs.muteCmd)
    else $error("pressel held but still muted");
  chk_vox_mute: assert property (@(posedge ref_clk) disable iff (rst)
    (keySelect == TMC_KEY_VOX && voiceMode && !speechF) |=> outs.muteCmd)
    else $error("no speech but not muted");
  chk_vox_unmute: assert property (@(posedge ref_clk) disable iff (rst)
    (keySelect == TMC_KEY_VOX && speechF && !faultLatch_nxt) |=> !outs.muteCmd)
    else $error("speech present but still muted");
  chk_tx_no_key: assert property (@(posedge ref_clk) disable iff (rst)
    (keySelect == TMC_KEY_TX && !faultLatch_nxt) |=> !outs.muteCmd)
    else $error("muted with plain keying selected");
  chk_mute_or: assert property (@(posedge ref_clk) disable iff (rst)
    (!faultLatch_nxt && !presselMute && !voxMute) |=> !outs.muteCmd)
    else $error("muted with no request");
  chk_mute_any: assert property (@(posedge ref_clk) disable iff (rst)
    (faultLatch_nxt || presselMute || voxMute) |=> outs.muteCmd)
    else $error("request present but not muted");

  ////////////////////////////////////////////////////////////////////////
  // checks: reset one-shot
  // pulse loads count
  chk_pulse_start: assert property (@(posedge ref_clk) disable iff (rst)
    (resetRise && !pulseActive) |=> (pulseCnt_r == PW'(RESET_PULSE_CYC)))
    else $error("reset pulse did not start");
  chk_pulse_no_retrig: assert property (@(posedge ref_clk) disable iff (rst)
    (resetRise && pulseActive) |=> (pulseCnt_r != PW'(RESET_PULSE_CYC)))
    else $error("reset pulse retriggered");
  chk_pulse_out: assert property (@(posedge ref_clk) disable iff (rst)
    pulseActive |=> outs.resetPulse)
    else $error("pulse running but not shown");
  chk_pulse_ends: assert property (@(posedge ref_clk) disable iff (rst)
    (pulseCnt_r == PW'(1)) |=> !pulseActive ##1 !outs.resetPulse)
    else $error("reset pulse overran");
  chk_pulse_clears: assert property (@(posedge ref_clk) disable iff (rst)
    (pulseActive && !faultSet) |=> (!faultLatch_r && !outs.resetLamp))
    else $error("pulse did not clear latch");
endmodule

// ---- src/tmc_consts.svh ----
// timing counts and reset values for the transmitter mute control
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH
`define TMC_CLK_HZ 25000000
`define TMC_CLK_PERIOD_NS 40
`define TMC_RESET_PULSE_MS 2000
`define TMC_RESET_PULSE_CYC ((`TMC_RESET_PULSE_MS * (`TMC_CLK_HZ / 1000)))
`define TMC_DEBOUNCE_US 1000
`define TMC_DEBOUNCE_CYC ((`TMC_DEBOUNCE_US * (`TMC_CLK_HZ / 1000000)))
`define TMC_LATCH_RESET_VAL 1'b1
`define TMC_SYNC_STAGES 3
`endif

// ---- src/tmc_pkg.sv ----
// types shared by the transmitter mute control
package tmc_pkg;
  typedef enum logic [1:0] {TMC_KEY_TX, TMC_KEY_PTT, TMC_KEY_VOX} tmc_key_e;
  typedef struct packed {
    logic ampFaultN;
    logic reducedPower;
    logic pressel;
    logic speechDetect;
    logic resetReq;
    logic lockLossN;
  } tmc_pins_s;
  typedef struct packed {
    logic muteCmd;
    logic resetLamp;
    logic reducedPowerLamp;
    logic resetPulse;
  } tmc_out_s;
endpackage

// ---- src/tmc_input_filter.sv ----
// three-stage synchroniser plus hold-off debounce for one pin
`timescale 1ns/1ps
`include "tmc_consts.svh"
module tmc_input_filter #(
  parameter int DEBOUNCE_CYC = `TMC_DEBOUNCE_CYC,
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // pin and filtered level
  input wire logic pinIn,
  output logic levelOut
);
  localparam int CW = $clog2(DEBOUNCE_CYC + 1);
  if (DEBOUNCE_CYC < 1) begin : gBadDebounce
    $error("debounce count must be at least one");
  end
  logic s1_r, s2_r, s3_r, level_r;
  logic [CW-1:0] cnt_r;
  wire agree = (s2_r == s3_r);
  wire differ = agree && (s3_r != level_r);
  wire done = (cnt_r == CW'(DEBOUNCE_CYC - 1));
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a level must hold steady the whole debounce span before it counts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      level_r <= RESET_VAL;
    end else if (!differ) begin
      cnt_r <= '0;
    end else if (done) begin
      cnt_r <= '0;
      level_r <= s3_r;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
  assign levelOut = level_r;
  chk_filter_settled: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(level_r) |-> ($past(done) && (level_r == $past(s3_r))))
    else $error("filtered level changed before debounce span");
endmodule

// ---- dv/tmc_amp_model.sv ----
// far-side model of the amplifier status lines
`timescale 1ns/1ps
module tmc_amp_model (
  // clock
  input wire logic ref_clk,
  // commands from the bench
  input wire logic faultCmd,
  input wire logic lossCmd,
  // status lines
  output logic ampFaultN,
  output logic lockLossN
);
  // one process drives both lines; reset covers the first whole cycle, until the first falling edge
  always @(negedge ref_clk) begin
    ampFaultN <= !faultCmd;
    lockLossN <= !lossCmd;
  end
endmodule

// ---- dv/transmitter_mute_control_bench.sv ----
// self-checking bench for the transmitter mute control
`timescale 1ns/1ps
module transmitter_mute_control_bench;
  import tmc_pkg::*;
  localparam int MUTE = 3;
  localparam int RLAMP = 2;
  localparam int PLAMP = 1;
  localparam int PULSE = 0;
  logic ref_clk = 1'b0, rst = 1'b1, faultCmd = 1'b0, lossCmd = 1'b0;
  logic ampFaultN, lockLossN, power = 1'b0, pressel = 1'b0, speech = 1'b0;
  logic resetReq = 1'b0, voiceMode = 1'b0;
  tmc_key_e keySelect = TMC_KEY_TX;
  tmc_pins_s pins;
  tmc_out_s outs;
  int badCount = 0, nCompared = 0;
  assign pins = {ampFaultN, power, pressel, speech, resetReq, lockLossN};
  tmc_amp_model amp (.ref_clk(ref_clk), .faultCmd(faultCmd), .lossCmd(lossCmd),
    .ampFaultN(ampFaultN), .lockLossN(lockLossN));
  // short counts keep the run brief
  tmc_mute_control #(.RESET_PULSE_CYC(20), .DEBOUNCE_CYC(3)) dut (.ref_clk(ref_clk),
    .rst(rst), .pins(pins), .keySelect(keySelect), .voiceMode(voiceMode), .outs(outs));
  initial forever #20 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic seen, input logic exp, input string what);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatched %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // bounded wait; filter latency is only roughly fixed
  task automatic waitOut(input int idx, input logic exp, input string what);
    int i;
    for (i = 0; i < 40 && outs[idx] !== exp; i++) cyc(1);
    check(outs[idx], exp, what);
    if (i == 40) results();
  endtask
  task automatic pressReset();
    int n;
    resetReq = 1'b1;
    waitOut(PULSE, 1'b1, "pulse start");
    for (n = 0; n < 40 && outs.resetPulse === 1'b1; n++) cyc(1);
    resetReq = 1'b0;
    check(n inside {[19:21]}, 1'b1, "pulse length");
    if (n == 40) results();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic testClear();
    check(outs.muteCmd, 1'b1, "mute at start");
    check(outs.resetLamp, 1'b1, "lamp at start");
    check(outs.reducedPowerLamp, 1'b0, "power lamp");
    pressReset();
    cyc(10);
    check(outs.resetLamp, 1'b0, "lamp cleared");
    check(outs.muteCmd, 1'b0, "unmuted");
    $display("clear done");
  endtask
  task automatic testFault();
    faultCmd = 1'b1;
    waitOut(RLAMP, 1'b1, "fault lamp");
    check(outs.muteCmd, 1'b1, "fault mute");
    pressReset();
    check(outs.resetLamp, 1'b1, "standing fault");
    faultCmd = 1'b0;
    cyc(12);
    check(outs.resetLamp, 1'b1, "latch held");
    pressReset();
    check(outs.muteCmd, 1'b0, "fault cleared");
    $display("fault done");
  endtask
  task automatic testPower();
    power = 1'b1;
    waitOut(PLAMP, 1'b1, "power lamp on");
    power = 1'b0;
    waitOut(PLAMP, 1'b0, "power lamp off");
    $display("power done");
  endtask
  task automatic testKeying();
    keySelect = TMC_KEY_PTT;
    waitOut(MUTE, 1'b1, "pressel released");
    pressel = 1'b1;
    waitOut(MUTE, 1'b0, "pressel held");
    keySelect = TMC_KEY_VOX;
    voiceMode = 1'b1;
    waitOut(MUTE, 1'b1, "no speech");
    speech = 1'b1;
    waitOut(MUTE, 1'b0, "speech");
    voiceMode = 1'b0;
    speech = 1'b0;
    cyc(12);
    check(outs.muteCmd, 1'b0, "voice mode off");
    voiceMode = 1'b1;
    waitOut(MUTE, 1'b1, "voice mode on");
    speech = 1'b1;
    waitOut(MUTE, 1'b0, "speech again");
    keySelect = TMC_KEY_TX;
    pressel = 1'b0;
    speech = 1'b0;
    cyc(12);
    check(outs.muteCmd, 1'b0, "plain keying");
    $display("keying done");
  endtask
  task automatic testLock();
    lossCmd = 1'b1;
    cyc(4);
    lossCmd = 1'b0;
    waitOut(MUTE, 1'b1, "lock mute");
    cyc(12);
    check(outs.resetLamp, 1'b1, "lock lamp");
    pressReset();
    check(outs.resetLamp, 1'b0, "lock cleared");
    $display("lock done");
  endtask
  task automatic testReset();
    int n;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(2);
    check(outs.muteCmd, 1'b1, "mute after reset");
    check(outs.resetLamp, 1'b1, "lamp after reset");
    check(outs.resetPulse, 1'b0, "pulse after reset");
    resetReq = 1'b1;
    waitOut(PULSE, 1'b1, "pulse after reset");
    resetReq = 1'b0;
    cyc(8);
    resetReq = 1'b1;
    for (n = 0; n < 40 && outs.resetPulse === 1'b1; n++) cyc(1);
    check(n < 40, 1'b1, "pulse end");
    if (n == 40) results();
    cyc(10);
    check(outs.resetPulse, 1'b0, "no retrigger");
    resetReq = 1'b0;
    check(outs.resetLamp, 1'b0, "lamp after pulse");
    check(outs.muteCmd, 1'b0, "unmuted after pulse");
    $display("reset done");
  endtask
  initial begin
    cyc(20);
    rst = 1'b0;
    cyc(2);
    testClear();
    testFault();
    testPower();
    testKeying();
    testLock();
    testReset();
    results();
  end
endmodule
